// ### common/quiet_decay_pkg.sv
// Shared constants and carriers for the quiet-decay register bank.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone bus.
`default_nettype none

package quiet_decay_pkg;

  // Bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h31;
  localparam logic [7:0] IDX_PROP   = 8'h32;
  localparam logic [7:0] IDX_INT    = 8'h33;
  localparam logic [7:0] IDX_DIV    = 8'h34;
  localparam logic [7:0] IDX_EXIT   = 8'h35;

  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PROP   = 8'h00;
  localparam logic [7:0] RST_INT    = 8'h00;
  localparam logic [7:0] RST_DIV    = 8'h00;
  localparam logic [7:0] RST_EXIT   = 8'hFF;

  // Field positions and widths
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_PWM_LSB  = 2;
  localparam int CFG_SMPL_LSB = 6;
  localparam int GAIN_W       = 7;
  localparam int KP_DIV_LSB   = 0;
  localparam int KI_DIV_LSB   = 4;
  localparam int DIV_W        = 3;

  // Zero-cross sampling codes
  localparam logic [1:0] SMPL_2US = 2'h0;
  localparam logic [1:0] SMPL_3US = 2'h1;
  localparam logic [1:0] SMPL_4US = 2'h2;

  // PWM rate codes and their rates in kHz
  localparam logic [1:0] PWM_25K = 2'h0;
  localparam logic [1:0] PWM_33K = 2'h1;
  localparam logic [1:0] PWM_42K = 2'h2;
  localparam logic [1:0] PWM_50K = 2'h3;
  localparam logic [5:0] KHZ_25  = 6'h19;
  localparam logic [5:0] KHZ_33  = 6'h21;
  localparam logic [5:0] KHZ_42  = 6'h2A;
  localparam logic [5:0] KHZ_50  = 6'h32;

  // Gain divider codes and the right shift each stands for
  localparam logic [2:0] DIV_32   = 3'h0;
  localparam logic [2:0] DIV_64   = 3'h1;
  localparam logic [2:0] DIV_128  = 3'h2;
  localparam logic [2:0] DIV_256  = 3'h3;
  localparam logic [2:0] DIV_512  = 3'h4;
  localparam logic [2:0] DIV_16   = 3'h5;
  localparam logic [2:0] DIV_NONE = 3'h6;
  localparam logic [3:0] SH_32    = 4'h5;
  localparam logic [3:0] SH_64    = 4'h6;
  localparam logic [3:0] SH_128   = 4'h7;
  localparam logic [3:0] SH_256   = 4'h8;
  localparam logic [3:0] SH_512   = 4'h9;
  localparam logic [3:0] SH_16    = 4'h4;
  localparam logic [3:0] SH_NONE  = 4'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SMPL_2US_NS   = 2000;
  localparam int SMPL_3US_NS   = 3000;
  localparam int SMPL_4US_NS   = 4000;
  localparam int SAMPLE_W      = 12;

  // Least time to whole cycles, never below one
  function automatic int cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [SAMPLE_W-1:0] SMPL_2US_CYC = SAMPLE_W'(cycles_min(SMPL_2US_NS));
  localparam logic [SAMPLE_W-1:0] SMPL_3US_CYC = SAMPLE_W'(cycles_min(SMPL_3US_NS));
  localparam logic [SAMPLE_W-1:0] SMPL_4US_CYC = SAMPLE_W'(cycles_min(SMPL_4US_NS));

  // Exit frequency: one count is 2 Hz
  localparam int EXIT_HZ_W = 9;

  // Byte address of a register index
  function automatic logic [ADR_W-1:0] reg_addr(input logic [7:0] idx);
    return ADR_W'({idx, 2'b00});
  endfunction

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic                 enable;
    logic [5:0]           pwm_khz;
    logic [SAMPLE_W-1:0]  sample_cycles;
    logic [EXIT_HZ_W-1:0] exit_hz;
  } quiet_cfg_t;

endpackage

`default_nettype wire

// ### src/quiet_gain_scale.sv
// Scales a raw controller gain by its power-of-two divider code.
// Assumes raw gain and code come from registers on the same clock.
`default_nettype none

module quiet_gain_scale #(
  parameter int FRAC_W = 9
) (
  input  wire logic                                     clk_i,
  input  wire logic                                     rst_i,
  input  wire logic                                     ce_i,
  input  wire logic [quiet_decay_pkg::GAIN_W-1:0]       raw_i,
  input  wire logic [quiet_decay_pkg::DIV_W-1:0]        div_i,
  output logic [quiet_decay_pkg::GAIN_W+FRAC_W-1:0]     gain_o
);
  import quiet_decay_pkg::*;

  localparam int GW = GAIN_W + FRAC_W;

  // Largest divider is 512, so nine fraction bits keep every result exact
  if (FRAC_W < 9) begin : g_frac_chk
    $error("FRAC_W below 9 loses gain resolution");
  end

  // Divider code to right shift; the unused code acts as the reset code
  function automatic logic [3:0] div_shift(input logic [DIV_W-1:0] code);
    case (code)
      DIV_32:   return SH_32;
      DIV_64:   return SH_64;
      DIV_128:  return SH_128;
      DIV_256:  return SH_256;
      DIV_512:  return SH_512;
      DIV_16:   return SH_16;
      DIV_NONE: return SH_NONE;
      default:  return SH_32;
    endcase
  endfunction

  // Fixed point result, FRAC_W fraction bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_o <= '0;
    end else if (ce_i) begin
      gain_o <= (GW'(raw_i) << FRAC_W) >> div_shift(div_i);
    end
  end

endmodule

`default_nettype wire

// ### src/zero_cross_window.sv
// Opens a sampling window of a set length on a zero-cross event.
// Assumes the start pulse comes from logic on the same clock.
`default_nettype none

module zero_cross_window (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_i,
  input  wire logic                                 ce_i,
  input  wire logic                                 start_i,
  input  wire logic [quiet_decay_pkg::SAMPLE_W-1:0] len_i,
  output logic                                      window_o,
  output logic                                      done_o
);
  import quiet_decay_pkg::*;

  logic [SAMPLE_W-1:0] remain;

  // Countdown; a new crossing inside an open window is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remain <= '0;
    end else if (ce_i) begin
      if (start_i && remain == '0) begin
        remain <= len_i;
      end else if (remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  // One pulse as the window closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= (remain == {{(SAMPLE_W-1){1'b0}}, 1'b1});
    end
  end

  // Window level from a flop; it follows the count one step ahead so it matches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_o <= 1'b0;
    end else if (ce_i) begin
      window_o <= (start_i && remain == '0 && len_i != '0) || (remain > SAMPLE_W'(1));
    end
  end

endmodule

`default_nettype wire

// ### src/quiet_decay_control_regs.sv
// Quiet-decay control register bank on a classic Wishbone slave.
// Assumes one 200 MHz clock; coil frequency and zero-cross come from same-clock logic.
//
// What this block does
// - Sampling code 00b, 01b, 10b give a zero-cross window of 2, 3 and 4 us.
// - PWM rate code 00b to 11b selects 25, 33, 42 or 50 kHz in quiet decay.
// - Bit 0 of the config register enables quiet decay, off after reset.
// - The proportional gain register holds a 7-bit raw gain, reset 0.
// - The integral gain register holds a 7-bit raw gain, reset 0.
// - Integral gain divider code at bits 6-4 divides by 32, 64, 128, 256, 512, 16 or 1.
// - Proportional gain divider code at bits 2-0 divides the same way.
// - The exit threshold counts 2 Hz per step, reset all ones for 510 Hz.
// - All five registers read and write; other offsets hold nothing.
`default_nettype none

module quiet_decay_control_regs #(
  parameter int FRAC_W = 9
) (
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_i,
  input  wire logic                                      ce_i,
  input  wire quiet_decay_pkg::wb_req_t                  wb_i,
  output logic                                           wb_ack_o,
  output logic [quiet_decay_pkg::DAT_W-1:0]              wb_dat_o,
  input  wire logic [quiet_decay_pkg::REG_W-1:0]         coil_freq_i,
  input  wire logic                                      zero_cross_i,
  output var quiet_decay_pkg::quiet_cfg_t                cfg_o,
  output logic [quiet_decay_pkg::GAIN_W+FRAC_W-1:0]      prop_gain_o,
  output logic [quiet_decay_pkg::GAIN_W+FRAC_W-1:0]      int_gain_o,
  output logic                                           quiet_active_o,
  output logic                                           sample_window_o,
  output logic                                           sample_done_o
);
  import quiet_decay_pkg::*;

  localparam int GW = GAIN_W + FRAC_W;

  // The gain scaler needs nine fraction bits for the /512 setting
  if (FRAC_W < 9) begin : g_frac_chk
    $error("FRAC_W below 9 loses gain resolution");
  end

  logic [REG_W-1:0] quiet_decay_config;
  logic [REG_W-1:0] quiet_decay_prop_gain;
  logic [REG_W-1:0] quiet_decay_int_gain;
  logic [REG_W-1:0] quiet_decay_gain_divider;
  logic [REG_W-1:0] quiet_decay_exit_threshold;

  logic             req;
  logic             wr_lane0;
  logic             rd_req;
  logic [DAT_W-1:0] next_rdata;
  quiet_cfg_t       next_cfg;

  logic             quiet_decay_enable;
  logic [1:0]       zero_cross_sample_time;
  logic [1:0]       quiet_decay_pwm_rate;
  logic [GAIN_W-1:0] quiet_prop_gain;
  logic [GAIN_W-1:0] quiet_integral_gain;
  logic [DIV_W-1:0] prop_gain_divider;
  logic [DIV_W-1:0] integral_gain_divider;
  logic [REG_W-1:0] quiet_decay_exit_freq;

  // Field views of the stored registers
  assign quiet_decay_enable     = quiet_decay_config[CFG_EN_BIT];
  assign zero_cross_sample_time = quiet_decay_config[CFG_SMPL_LSB +: 2];
  assign quiet_decay_pwm_rate   = quiet_decay_config[CFG_PWM_LSB +: 2];
  assign quiet_prop_gain        = quiet_decay_prop_gain[GAIN_W-1:0];
  assign quiet_integral_gain    = quiet_decay_int_gain[GAIN_W-1:0];
  assign prop_gain_divider      = quiet_decay_gain_divider[KP_DIV_LSB +: DIV_W];
  assign integral_gain_divider  = quiet_decay_gain_divider[KI_DIV_LSB +: DIV_W];
  assign quiet_decay_exit_freq  = quiet_decay_exit_threshold;

  // Request qualifiers; the ack term keeps a held request from acting twice
  assign req      = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr_lane0 = req && wb_i.we && wb_i.sel[0];
  assign rd_req   = req && !wb_i.we;

  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  // Register writes; only byte lane 0 carries data, reserved bits are stored too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet_decay_config         <= RST_CONFIG;
      quiet_decay_prop_gain      <= RST_PROP;
      quiet_decay_int_gain       <= RST_INT;
      quiet_decay_gain_divider   <= RST_DIV;
      quiet_decay_exit_threshold <= RST_EXIT;
    end else if (ce_i && wr_lane0) begin
      unique case (wb_i.adr)
        reg_addr(IDX_CONFIG): quiet_decay_config         <= wb_i.dat[REG_W-1:0];
        reg_addr(IDX_PROP):   quiet_decay_prop_gain      <= wb_i.dat[REG_W-1:0];
        reg_addr(IDX_INT):    quiet_decay_int_gain       <= wb_i.dat[REG_W-1:0];
        reg_addr(IDX_DIV):    quiet_decay_gain_divider   <= wb_i.dat[REG_W-1:0];
        reg_addr(IDX_EXIT):   quiet_decay_exit_threshold <= wb_i.dat[REG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    next_rdata = '0;
    unique case (wb_i.adr)
      reg_addr(IDX_CONFIG): next_rdata = DAT_W'(quiet_decay_config);
      reg_addr(IDX_PROP):   next_rdata = DAT_W'(quiet_decay_prop_gain);
      reg_addr(IDX_INT):    next_rdata = DAT_W'(quiet_decay_int_gain);
      reg_addr(IDX_DIV):    next_rdata = DAT_W'(quiet_decay_gain_divider);
      reg_addr(IDX_EXIT):   next_rdata = DAT_W'(quiet_decay_exit_threshold);
      default:              next_rdata = '0;
    endcase
  end

  // Read data is latched with the ack; writes answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && req) begin
      wb_dat_o <= rd_req ? next_rdata : '0;
    end
  end

  // Decode of the operating settings
  always_comb begin
    next_cfg        = '0;
    next_cfg.enable = quiet_decay_enable;
    case (zero_cross_sample_time)
      SMPL_2US: next_cfg.sample_cycles = SMPL_2US_CYC;
      SMPL_3US: next_cfg.sample_cycles = SMPL_3US_CYC;
      SMPL_4US: next_cfg.sample_cycles = SMPL_4US_CYC;
      default:  next_cfg.sample_cycles = SMPL_2US_CYC;
    endcase
    unique case (quiet_decay_pwm_rate)
      PWM_25K: next_cfg.pwm_khz = KHZ_25;
      PWM_33K: next_cfg.pwm_khz = KHZ_33;
      PWM_42K: next_cfg.pwm_khz = KHZ_42;
      PWM_50K: next_cfg.pwm_khz = KHZ_50;
    endcase
    // Two hertz per count is one left shift
    next_cfg.exit_hz = {quiet_decay_exit_freq, 1'b0};
  end

  // Settings leave through a register so a write lands as a clean step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else if (ce_i) begin
      cfg_o <= next_cfg;
    end
  end

  // Quiet decay runs only while enabled and the coil is below the exit rate;
  // a zero threshold would keep it off for good
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet_active_o <= 1'b0;
    end else if (ce_i) begin
      quiet_active_o <= quiet_decay_enable
                        && (coil_freq_i < quiet_decay_exit_freq);
    end
  end

  // Proportional gain after its divider
  quiet_gain_scale #(
    .FRAC_W (FRAC_W)
  ) u_prop_scale (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .raw_i  (quiet_prop_gain),
    .div_i  (prop_gain_divider),
    .gain_o (prop_gain_o)
  );

  // Integral gain after its divider
  quiet_gain_scale #(
    .FRAC_W (FRAC_W)
  ) u_int_scale (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .raw_i  (quiet_integral_gain),
    .div_i  (integral_gain_divider),
    .gain_o (int_gain_o)
  );

  // Zero-cross window, armed only while quiet decay is enabled
  zero_cross_window u_window (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .start_i  (zero_cross_i && cfg_o.enable),
    .len_i    (cfg_o.sample_cycles),
    .window_o (sample_window_o),
    .done_o   (sample_done_o)
  );

  // Checks on the bus and the decoded settings
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Every taken request is acknowledged at the next edge
  a_ack_after_req: assert property (
    (ce_i && req) |=> wb_ack_o
  ) else $error("request not acknowledged");

  // Ack stands a single cycle
  a_ack_one_cycle: assert property (
    (ce_i && wb_ack_o) |=> !wb_ack_o
  ) else $error("ack held too long");

  // A config write stores every bit as written
  a_config_write: assert property (
    (ce_i && wr_lane0 && wb_i.adr == reg_addr(IDX_CONFIG))
    |=> quiet_decay_config == $past(wb_i.dat[REG_W-1:0])
  ) else $error("config write not stored");

  // Proportional gain reads back with zero upper bits
  a_prop_readback: assert property (
    (ce_i && rd_req && wb_i.adr == reg_addr(IDX_PROP))
    |=> wb_ack_o && wb_dat_o == DAT_W'($past(quiet_decay_prop_gain))
  ) else $error("prop gain read wrong");

  // Four microsecond window code
  a_sample_4us: assert property (
    (ce_i && zero_cross_sample_time == SMPL_4US) |=> cfg_o.sample_cycles == 12'h320
  ) else $error("4 us window wrong");

  // Unused sampling code falls back to two microseconds
  a_sample_unused: assert property (
    (ce_i && zero_cross_sample_time == 2'h3) |=> cfg_o.sample_cycles == 12'h190
  ) else $error("unused sample code not 2 us");

  // Highest PWM rate
  a_pwm_50k: assert property (
    (ce_i && quiet_decay_pwm_rate == PWM_50K) |=> cfg_o.pwm_khz == 6'h32
  ) else $error("pwm rate not 50 kHz");

  // Disabled mode never runs
  a_enable_gate: assert property (
    (ce_i && !quiet_decay_enable) |=> !quiet_active_o
  ) else $error("quiet decay active while disabled");

  // Leaving at and above the threshold, and its value in hertz
  a_exit_freq: assert property (
    (ce_i && coil_freq_i >= quiet_decay_exit_freq)
    |=> !quiet_active_o && cfg_o.exit_hz == 2 * $past(quiet_decay_exit_freq)
  ) else $error("exit threshold not honoured");

  // No division gives the raw gain
  a_prop_bypass: assert property (
    (ce_i && prop_gain_divider == DIV_NONE)
    |=> prop_gain_o == (GW'($past(quiet_prop_gain)) << FRAC_W)
  ) else $error("prop gain bypass wrong");

  // Reset divider code is divide by 32
  a_int_div32: assert property (
    (ce_i && integral_gain_divider == DIV_32)
    |=> int_gain_o == (GW'($past(quiet_integral_gain)) << (FRAC_W - 5))
  ) else $error("int gain /32 wrong");

  // A frozen clock enable holds the bus answer
  a_ce_hold_ack: assert property (
    !ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o)
  ) else $error("bus answer moved while frozen");

  // A frozen clock enable holds every setting
  a_ce_hold_cfg: assert property (
    !ce_i |=> $stable(cfg_o) && $stable(quiet_active_o)
  ) else $error("settings moved while frozen");

  // A write with byte lane 0 off leaves the registers alone
  a_lane_off_write: assert property (
    (ce_i && req && wb_i.we && !wb_i.sel[0])
    |=> $stable(quiet_decay_prop_gain) && $stable(quiet_decay_config)
  ) else $error("write with lane 0 off changed a register");

  // Write acks carry no data
  a_write_dat_zero: assert property (
    (ce_i && req && wb_i.we) |=> wb_dat_o == '0
  ) else $error("write ack carried data");

  // Exit threshold reads back as written
  a_exit_readback: assert property (
    (ce_i && rd_req && wb_i.adr == reg_addr(IDX_EXIT))
    |=> wb_dat_o == DAT_W'($past(quiet_decay_exit_threshold))
  ) else $error("exit threshold read wrong");

  // Enabled and below the threshold, quiet decay runs
  a_active_below: assert property (
    (ce_i && quiet_decay_enable && coil_freq_i < quiet_decay_exit_freq) |=> quiet_active_o
  ) else $error("quiet decay not active below threshold");

  // Three microsecond window code
  a_sample_3us: assert property (
    (ce_i && zero_cross_sample_time == SMPL_3US) |=> cfg_o.sample_cycles == 12'h258
  ) else $error("3 us window wrong");

  // Unused divider code acts as divide by 32
  a_prop_div_unused: assert property (
    (ce_i && prop_gain_divider == 3'h7)
    |=> prop_gain_o == (GW'($past(quiet_prop_gain)) << (FRAC_W - 5))
  ) else $error("unused prop divider not /32");

endmodule

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the quiet-decay register bank.
// Assumes the package and all design sources are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import quiet_decay_pkg::*;

  localparam int FRAC = 9;
  localparam int GW   = GAIN_W + FRAC;

  logic                 clk_i;
  logic                 rst_i;
  logic                 ce_i;
  wb_req_t              wb_i;
  logic                 wb_ack_o;
  logic [DAT_W-1:0]     wb_dat_o;
  logic [REG_W-1:0]     coil_freq_i;
  logic                 zero_cross_i;
  quiet_cfg_t           cfg_o;
  logic [GW-1:0]        prop_gain_o;
  logic [GW-1:0]        int_gain_o;
  logic                 quiet_active_o;
  logic                 sample_window_o;
  logic                 sample_done_o;
  logic [31:0]          exp_q[$];
  logic [7:0]           mdl [8'h31:8'h35];
  int                   error_cnt;
  int                   check_count;
  int                   cyc_cnt;

  quiet_decay_control_regs #(.FRAC_W(FRAC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .coil_freq_i(coil_freq_i), .zero_cross_i(zero_cross_i),
    .cfg_o(cfg_o), .prop_gain_o(prop_gain_o), .int_gain_o(int_gain_o),
    .quiet_active_o(quiet_active_o), .sample_window_o(sample_window_o),
    .sample_done_o(sample_done_o)
  );

  // Free-running 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_dat(input logic [31:0] got, input logic [31:0] exp);
    chk_val(got, exp, "bus data");
  endtask

  // Hang guard; the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Monitor: every ack retires the oldest expected word
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_val(32'h1, 32'h0, "unexpected ack");
      end else begin
        chk_dat(wb_dat_o, exp_q.pop_front());
      end
    end
  end

  // One classic cycle; write acks carry zero data
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                         input logic [3:0] sel, input logic [31:0] exp);
    wb_req_t r;
    int      n;
    r = '0;
    r.cyc = 1'b1;
    r.stb = 1'b1;
    r.we  = we;
    r.sel = sel;
    r.adr = {idx[5:0], 2'b00};
    r.dat = {24'h0, wd};
    @(posedge clk_i);
    wb_i <= r;
    exp_q.push_back(exp);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    wb_i <= '0;
    if (n >= 50) chk_val(32'h1, 32'h0, "no ack");
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_xfer(1'b1, idx, d, 4'hF, 32'h0);
    if (idx >= 8'h31 && idx <= 8'h35) mdl[idx] = d;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb_xfer(1'b0, idx, 8'h00, 4'hF, {24'h0, e});
  endtask

  // Let register and decode flops land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [31:0] smpl_cyc(input logic [1:0] c);
    return (c == 2'h1) ? 32'd600 : (c == 2'h2) ? 32'd800 : 32'd400;
  endfunction

  function automatic logic [31:0] gain_exp(input logic [6:0] raw, input logic [2:0] c);
    int sh [8] = '{5, 6, 7, 8, 9, 4, 0, 5};
    return 32'((GW'(raw) << FRAC) >> sh[c]);
  endfunction

  // Main sequence
  initial begin
    logic [7:0]  d;
    logic [6:0]  kp;
    logic [6:0]  ki;
    logic [31:0] kmap [4];
    int          n;
    logic        dn;
    error_cnt = 0;
    check_count = 0;
    cyc_cnt = 0;
    kmap = '{32'd25, 32'd33, 32'd42, 32'd50};
    void'($urandom(731));
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_i = '0;
    coil_freq_i = 8'h00;
    zero_cross_i = 1'b0;
    mdl[8'h31] = 8'h00;
    mdl[8'h32] = 8'h00;
    mdl[8'h33] = 8'h00;
    mdl[8'h34] = 8'h00;
    mdl[8'h35] = 8'hFF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, reserved offsets read as zero
    for (int i = 8'h31; i <= 8'h35; i++) rd(8'(i), mdl[i]);
    rd(8'h30, 8'h00);
    rd(8'h36, 8'h00);
    settle(2);
    chk_val(32'(cfg_o.enable), 32'h0, "enable");
    chk_val(32'(cfg_o.pwm_khz), 32'd25, "pwm");
    chk_val(32'(cfg_o.sample_cycles), 32'd400, "sample");
    chk_val(32'(cfg_o.exit_hz), 32'd510, "exit hz");
    // Random readback of every bit; threshold kept nonzero by software
    for (int i = 8'h31; i <= 8'h35; i++) begin
      d = 8'($urandom);
      if (i == 8'h35 && d == 8'h00) d = 8'h01;
      wr(8'(i), d);
      rd(8'(i), d);
    end
    // Reserved offset only gets back what it reads; lane 0 off changes nothing
    wb_xfer(1'b1, 8'h36, 8'h00, 4'hF, 32'h0);
    wb_xfer(1'b1, 8'h32, 8'h55, 4'hE, 32'h0);
    rd(8'h32, mdl[8'h32]);
    rd(8'h36, 8'h00);
    // Every sampling and PWM code, enable toggled along the way
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(8'h31, {2'(s), 2'b00, 2'(p), 1'b0, 1'(p)});
        settle(2);
        chk_val(32'(cfg_o.sample_cycles), smpl_cyc(2'(s)), "sample");
        chk_val(32'(cfg_o.pwm_khz), kmap[p], "pwm");
        chk_val(32'(cfg_o.enable), 32'(p & 1), "enable");
      end
    end
    rd(8'h31, mdl[8'h31]);
    // Every divider code on both gains, including the unused one
    for (int c = 0; c < 8; c++) begin
      kp = (c == 0) ? 7'h7F : 7'($urandom);
      ki = 7'($urandom);
      wr(8'h32, {1'b0, kp});
      wr(8'h33, {1'b0, ki});
      wr(8'h34, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      settle(2);
      chk_val(32'(prop_gain_o), gain_exp(kp, 3'(c)), "kp");
      chk_val(32'(int_gain_o), gain_exp(ki, 3'(7 - c)), "ki");
    end
    rd(8'h34, mdl[8'h34]);
    // Exit threshold scale and the strict frequency compare
    d = 8'($urandom_range(254, 2));
    wr(8'h35, d);
    wr(8'h31, 8'h01);
    @(posedge clk_i);
    coil_freq_i <= d - 8'h01;
    settle(3);
    chk_val(32'(cfg_o.exit_hz), 32'(d) * 2, "exit hz");
    chk_val(32'(quiet_active_o), 32'h1, "active below");
    // Clock enable low freezes the flag although the coil reaches the threshold
    @(posedge clk_i);
    ce_i <= 1'b0;
    coil_freq_i <= d;
    settle(3);
    chk_val(32'(quiet_active_o), 32'h1, "active frozen");
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(3);
    chk_val(32'(quiet_active_o), 32'h0, "active at");
    wr(8'h31, 8'h00);
    @(posedge clk_i);
    coil_freq_i <= 8'h00;
    settle(3);
    chk_val(32'(quiet_active_o), 32'h0, "active off");
    // Window length for each documented code, lengthened step by step as on distortion
    for (int s = 0; s < 3; s++) begin
      wr(8'h31, {2'(s), 6'h01});
      settle(2);
      @(posedge clk_i);
      zero_cross_i <= 1'b1;
      @(posedge clk_i);
      zero_cross_i <= 1'b0;
      n = 0;
      dn = 1'b0;
      for (int k = 0; k < 1000 && !dn; k++) begin
        @(posedge clk_i);
        if (sample_window_o === 1'b1) n++;
        if (sample_done_o === 1'b1) dn = 1'b1;
      end
      chk_val(32'(n), smpl_cyc(2'(s)), "window");
      chk_val(32'(dn), 32'h1, "done");
    end
    settle(2);
    chk_val(32'(exp_q.size()), 32'h0, "acks missing");
    give_verdict();
  end

endmodule

`default_nettype wire
